//--- inc/threshold_cmp_pkg.sv
// constants for the two-channel threshold comparator
// assumes a byte-wide register port behind the chip's serial host interface
package threshold_cmp_pkg;

    // =========================================================
    // register offsets
    localparam logic [7:0] chan_a_counter_control_offset   = 8'h34;
    localparam logic [7:0] channel_a_reference_offset      = 8'h35;
    localparam logic [7:0] channel_b_counter_control_offset = 8'h36;
    localparam logic [7:0] channel_b_reference_offset      = 8'h37;
    localparam logic [7:0] comparator_source_enable_offset = 8'h38;

    // =========================================================
    // reset values
    localparam logic [7:0] register_reset_value = 8'h00;
    localparam logic [7:0] unmapped_read_value  = 8'h00;

    // =========================================================
    // field positions
    localparam int start_edge_bit     = 7;
    localparam int counter_msb        = 6;
    localparam int chan_b_enable_bit  = 0;
    localparam int chan_b_source_lsb  = 1;
    localparam int chan_a_enable_bit  = 3;
    localparam int chan_a_source_lsb  = 4;
    localparam int result_compare_msb = 9;
    localparam int result_compare_lsb = 2;

    // =========================================================
    // counter limit
    localparam logic [6:0] counter_max = 7'h7f;

    // =========================================================
    // source select codes
    typedef enum logic [1:0] {
        source_voltage     = 2'h0,
        source_temperature = 2'h1,
        source_current     = 2'h2,
        source_general_pin = 2'h3
    } source_select_type;

endpackage

//--- rtl/threshold_channel.sv
// one comparator channel: threshold compare, edge arm and 7-bit counter
// assumes the sample and its done strobe are synchronous to clock_i
`timescale 1ns/1ps

module threshold_channel #(
    parameter int result_width = 10,
    parameter int count_width  = 7
) (
    // clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    rst_i,
    // control
    input  wire logic                    enable_i,
    input  wire logic                    start_edge_i,
    input  wire logic [7:0]              threshold_i,
    input  wire logic                    load_i,
    input  wire logic [count_width-1:0]  load_value_i,
    // sample
    input  wire logic [result_width-1:0] sample_i,
    input  wire logic                    sample_done_i,
    // state
    output logic                         compare_o,
    output logic [count_width-1:0]       counter_o
);

    logic compare_prev_reg;
    logic running_reg;
    logic start_seen;

    // =========================================================
    // compare on upper result bits
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            compare_o <= 1'b0;
        end else begin
            compare_o <= enable_i &&
                (sample_i[threshold_cmp_pkg::result_compare_msb:
                          threshold_cmp_pkg::result_compare_lsb] >= threshold_i);
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            compare_prev_reg <= 1'b0;
        end else begin
            compare_prev_reg <= compare_o;
        end
    end

    // =========================================================
    // start edge selection
    assign start_seen = enable_i && (start_edge_i ? (compare_o && !compare_prev_reg)
                                                  : (!compare_o && compare_prev_reg));

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            running_reg <= 1'b0;
        end else if (load_i || !enable_i) begin
            running_reg <= 1'b0;
        end else if (start_seen) begin
            running_reg <= 1'b1;
        end
    end

    load_disarm_a: assert property (@(posedge clock_i) disable iff (rst_i)
        load_i |=> !running_reg)
        else $error("counter still armed after load");

    // =========================================================
    // counter, saturating
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            counter_o <= '0;
        end else if (load_i) begin
            counter_o <= load_value_i;
        end else if (start_seen) begin
            counter_o <= '0;
        end else if (running_reg && sample_done_i && (counter_o != {count_width{1'b1}})) begin
            counter_o <= counter_o + 1'b1;
        end
    end

endmodule

//--- rtl/threshold_comparator.sv
// register file, source selection and both comparator channels
// assumes a byte register port driven by the serial host interface
`timescale 1ns/1ps

// Notes on behaviour
// - each channel compares selected result bits 9..2 with its 8-bit reference
// - channel B counter 0..127; start edge bit 0 falling, 1 rising
// - channel A has the same counter and start edge choice
// - channel B compares only while its enable bit is set; reset disabled
// - channel A enable is bit 3 of select register; reset disabled
// - channel B source: voltage, temperature, current, first general pin
// - channel A source: same codes, but 3 picks the second general pin
module threshold_comparator #(
    parameter int result_width = 10,
    parameter int count_width  = 7
) (
    // clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    rst_i,
    // register port
    input  wire logic [7:0]              reg_addr_i,
    input  wire logic [7:0]              reg_wdata_i,
    input  wire logic                    reg_write_i,
    input  wire logic                    reg_read_i,
    output logic [7:0]                   reg_rdata_o,
    // conversion results
    input  wire logic [result_width-1:0] voltage_result_i,
    input  wire logic [result_width-1:0] temperature_result_i,
    input  wire logic [result_width-1:0] current_result_i,
    input  wire logic [result_width-1:0] general_pin_one_result_i,
    input  wire logic [result_width-1:0] general_pin_two_result_i,
    input  wire logic                    conversion_done_i,
    // comparator outputs
    output logic                         chan_a_compare_o,
    output logic                         chan_b_compare_o
);

    logic [7:0]              chan_a_threshold_reg;
    logic [7:0]              chan_b_threshold_reg;
    logic                    chan_a_start_edge_reg;
    logic                    chan_b_start_edge_reg;
    logic [7:0]              select_reg;
    logic                    chan_a_enable;
    logic                    chan_b_enable;
    logic [1:0]              chan_a_source_select;
    logic [1:0]              chan_b_source_select;
    logic [result_width-1:0] chan_a_sample;
    logic [result_width-1:0] chan_b_sample;
    logic                    chan_a_load;
    logic                    chan_b_load;
    logic [count_width-1:0]  chan_a_counter;
    logic [count_width-1:0]  chan_b_counter;
    logic [7:0]              reg_rdata_next;

    // =========================================================
    // register writes
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            chan_a_threshold_reg <= threshold_cmp_pkg::register_reset_value;
            chan_b_threshold_reg <= threshold_cmp_pkg::register_reset_value;
            select_reg           <= threshold_cmp_pkg::register_reset_value;
        end else if (reg_write_i) begin
            case (reg_addr_i)
                threshold_cmp_pkg::channel_a_reference_offset: begin
                    chan_a_threshold_reg <= reg_wdata_i;
                end
                threshold_cmp_pkg::channel_b_reference_offset: begin
                    chan_b_threshold_reg <= reg_wdata_i;
                end
                threshold_cmp_pkg::comparator_source_enable_offset: begin
                    select_reg <= {2'h0, reg_wdata_i[5:0]};
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            chan_a_start_edge_reg <= 1'b0;
            chan_b_start_edge_reg <= 1'b0;
        end else begin
            if (chan_a_load) begin
                chan_a_start_edge_reg <= reg_wdata_i[threshold_cmp_pkg::start_edge_bit];
            end
            if (chan_b_load) begin
                chan_b_start_edge_reg <= reg_wdata_i[threshold_cmp_pkg::start_edge_bit];
            end
        end
    end

    assign chan_a_load = reg_write_i &&
        (reg_addr_i == threshold_cmp_pkg::chan_a_counter_control_offset);
    assign chan_b_load = reg_write_i &&
        (reg_addr_i == threshold_cmp_pkg::channel_b_counter_control_offset);

    assign chan_a_enable = select_reg[threshold_cmp_pkg::chan_a_enable_bit];
    assign chan_b_enable = select_reg[threshold_cmp_pkg::chan_b_enable_bit];
    assign chan_a_source_select = select_reg[threshold_cmp_pkg::chan_a_source_lsb +: 2];
    assign chan_b_source_select = select_reg[threshold_cmp_pkg::chan_b_source_lsb +: 2];

    // =========================================================
    // source selection
    always_comb begin
        case (chan_a_source_select)
            threshold_cmp_pkg::source_voltage:     chan_a_sample = voltage_result_i;
            threshold_cmp_pkg::source_temperature: chan_a_sample = temperature_result_i;
            threshold_cmp_pkg::source_current:     chan_a_sample = current_result_i;
            default:                               chan_a_sample = general_pin_two_result_i;
        endcase
    end

    always_comb begin
        case (chan_b_source_select)
            threshold_cmp_pkg::source_voltage:     chan_b_sample = voltage_result_i;
            threshold_cmp_pkg::source_temperature: chan_b_sample = temperature_result_i;
            threshold_cmp_pkg::source_current:     chan_b_sample = current_result_i;
            default:                               chan_b_sample = general_pin_one_result_i;
        endcase
    end

    // =========================================================
    // channels
    threshold_channel #(
        .result_width (result_width),
        .count_width  (count_width)
    ) chan_a_unit (
        .clock_i       (clock_i),
        .rst_i         (rst_i),
        .enable_i      (chan_a_enable),
        .start_edge_i  (chan_a_start_edge_reg),
        .threshold_i   (chan_a_threshold_reg),
        .load_i        (chan_a_load),
        .load_value_i  (reg_wdata_i[count_width-1:0]),
        .sample_i      (chan_a_sample),
        .sample_done_i (conversion_done_i),
        .compare_o     (chan_a_compare_o),
        .counter_o     (chan_a_counter)
    );

    threshold_channel #(
        .result_width (result_width),
        .count_width  (count_width)
    ) chan_b_unit (
        .clock_i       (clock_i),
        .rst_i         (rst_i),
        .enable_i      (chan_b_enable),
        .start_edge_i  (chan_b_start_edge_reg),
        .threshold_i   (chan_b_threshold_reg),
        .load_i        (chan_b_load),
        .load_value_i  (reg_wdata_i[count_width-1:0]),
        .sample_i      (chan_b_sample),
        .sample_done_i (conversion_done_i),
        .compare_o     (chan_b_compare_o),
        .counter_o     (chan_b_counter)
    );

    // =========================================================
    // register reads
    always_comb begin
        case (reg_addr_i)
            threshold_cmp_pkg::chan_a_counter_control_offset:
                reg_rdata_next = {chan_a_start_edge_reg, chan_a_counter};
            threshold_cmp_pkg::channel_a_reference_offset:
                reg_rdata_next = chan_a_threshold_reg;
            threshold_cmp_pkg::channel_b_counter_control_offset:
                reg_rdata_next = {chan_b_start_edge_reg, chan_b_counter};
            threshold_cmp_pkg::channel_b_reference_offset:
                reg_rdata_next = chan_b_threshold_reg;
            threshold_cmp_pkg::comparator_source_enable_offset:
                reg_rdata_next = select_reg;
            default:
                reg_rdata_next = threshold_cmp_pkg::unmapped_read_value;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= threshold_cmp_pkg::unmapped_read_value;
        end else if (reg_read_i) begin
            reg_rdata_o <= reg_rdata_next;
        end
    end

    // =========================================================
    // checks
    sequence a_rise_seq;
        chan_a_enable && chan_a_start_edge_reg && !chan_a_load && chan_a_compare_o
            && !$past(chan_a_compare_o);
    endsequence

    sequence b_fall_seq;
        chan_b_enable && !chan_b_start_edge_reg && !chan_b_load && !chan_b_compare_o
            && $past(chan_b_compare_o);
    endsequence

    compare_a_level_a: assert property (@(posedge clock_i) disable iff (rst_i)
        ##1 chan_a_compare_o == ($past(chan_a_enable) &&
            ($past(chan_a_sample[9:2]) >= $past(chan_a_threshold_reg))))
        else $error("channel a compare level wrong");

    compare_b_level_a: assert property (@(posedge clock_i) disable iff (rst_i)
        ##1 chan_b_compare_o == ($past(chan_b_enable) &&
            ($past(chan_b_sample[9:2]) >= $past(chan_b_threshold_reg))))
        else $error("channel b compare level wrong");

    a_disabled_low_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !chan_a_enable [*2] |-> !chan_a_compare_o)
        else $error("channel a compares while disabled");

    b_disabled_low_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !chan_b_enable [*2] |-> !chan_b_compare_o)
        else $error("channel b compares while disabled");

    a_pin_two_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (chan_a_source_select == 2'h3) |-> (chan_a_sample == general_pin_two_result_i))
        else $error("channel a source three not second pin");

    b_pin_one_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (chan_b_source_select == 2'h3) |-> (chan_b_sample == general_pin_one_result_i))
        else $error("channel b source three not first pin");

    a_rise_start_a: assert property (@(posedge clock_i) disable iff (rst_i)
        a_rise_seq |=> (chan_a_counter == 7'h00))
        else $error("channel a rising start not taken");

    b_fall_start_a: assert property (@(posedge clock_i) disable iff (rst_i)
        b_fall_seq |=> (chan_b_counter == 7'h00))
        else $error("channel b falling start not taken");

    b_saturate_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (chan_b_counter == threshold_cmp_pkg::counter_max) && !chan_b_load
            && !(!chan_b_start_edge_reg && !chan_b_compare_o && $past(chan_b_compare_o))
            && !(chan_b_start_edge_reg && chan_b_compare_o && !$past(chan_b_compare_o))
            |=> (chan_b_counter == threshold_cmp_pkg::counter_max))
        else $error("channel b counter wrapped");

    count_step_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !chan_a_load ##1 (!chan_a_load && $changed(chan_a_counter) && chan_a_counter != 7'h00)
            |-> $past(conversion_done_i) && chan_a_counter == $past(chan_a_counter) + 7'h01)
        else $error("channel a counter moved without conversion");

    reset_clear_a: assert property (@(posedge clock_i)
        $fell(rst_i) |-> !chan_b_enable && !chan_a_enable && chan_b_threshold_reg == 8'h00)
        else $error("registers not cleared by reset");

endmodule

//--- verification/host_model.sv
// host side model: byte register writes and reads on the register port
// assumes the bench clock; strobes change at the falling edge only
`timescale 1ns/1ps

module host_model (
    // clock
    input  wire logic       clock_i,
    // register port
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o,
    output logic            reg_write_o,
    output logic            reg_read_o,
    input  wire logic [7:0] reg_rdata_i
);
    // =========================================================
    // idle values
    initial begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        reg_write_o = 1'b0;
        reg_read_o  = 1'b0;
    end

    // =========================================================
    // access tasks, one-cycle strobe, bus scrambled when released
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock_i);
        reg_addr_o  = addr;
        reg_wdata_o = data;
        reg_write_o = 1'b1;
        @(negedge clock_i);
        reg_write_o = 1'b0;
        reg_addr_o  = ~addr;
        reg_wdata_o = ~data;
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clock_i);
        reg_addr_o = addr;
        reg_read_o = 1'b1;
        @(negedge clock_i);
        reg_read_o = 1'b0;
        reg_addr_o = ~addr;
        data       = reg_rdata_i;
    endtask
endmodule

//--- verification/testbench.sv
// self-checking bench for the two-channel threshold comparator
// assumes host_model drives the register port; bench drives results
`timescale 1ns/1ps

module testbench;
    // =========================================================
    // signals
    logic       clock;
    logic       rst;
    logic [9:0] results [5];
    logic       done;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       chan_a_cmp;
    logic       chan_b_cmp;
    int         bad_count;
    int         n_compared;
    logic [7:0] refs [7];
    logic [9:0] vals [7];
    logic       exps [7];

    // =========================================================
    // clock, design and host
    initial clock = 1'b0;
    always #2 clock = ~clock;

    threshold_comparator u_dut (
        .clock_i                  (clock),
        .rst_i                    (rst),
        .reg_addr_i               (addr),
        .reg_wdata_i              (wdata),
        .reg_write_i              (wr),
        .reg_read_i               (rd),
        .reg_rdata_o              (rdata),
        .voltage_result_i         (results[0]),
        .temperature_result_i     (results[1]),
        .current_result_i         (results[2]),
        .general_pin_one_result_i (results[3]),
        .general_pin_two_result_i (results[4]),
        .conversion_done_i        (done),
        .chan_a_compare_o         (chan_a_cmp),
        .chan_b_compare_o         (chan_b_cmp)
    );

    host_model u_host (
        .clock_i     (clock),
        .reg_addr_o  (addr),
        .reg_wdata_o (wdata),
        .reg_write_o (wr),
        .reg_read_o  (rd),
        .reg_rdata_i (rdata)
    );

    // =========================================================
    // checking tasks
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic read_check(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] data;
        u_host.read_reg(a, data);
        check(what, data, exp);
    endtask

    task automatic check_cmp(input logic exp_a, input logic exp_b);
        repeat (3) @(negedge clock);
        check("chan_a_compare", {7'h00, chan_a_cmp}, {7'h00, exp_a});
        check("chan_b_compare", {7'h00, chan_b_cmp}, {7'h00, exp_b});
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            @(negedge clock);
            done = 1'b1;
            @(negedge clock);
            done = 1'b0;
        end
    endtask

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // =========================================================
    // watchdog
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        end_sim();
    end

    // =========================================================
    // tests
    initial begin
        rst = 1'b1;
        done = 1'b0;
        bad_count = 0;
        n_compared = 0;
        foreach (results[j]) results[j] = 10'h000;
        repeat (10) @(negedge clock);
        rst = 1'b0;
        // reset values and unmapped place
        for (int k = 8'h34; k <= 8'h39; k++) begin
            read_check("reset value", k[7:0], 8'h00);
        end
        // enables gate the compare
        results[0] = 10'h3ff;
        check_cmp(1'b0, 1'b0);
        u_host.write_reg(8'h38, 8'h01);
        check_cmp(1'b0, 1'b1);
        u_host.write_reg(8'h38, 8'h08);
        check_cmp(1'b1, 1'b0);
        // register readback
        u_host.write_reg(8'h35, 8'ha5);
        u_host.write_reg(8'h37, 8'h5a);
        u_host.write_reg(8'h38, 8'hff);
        u_host.write_reg(8'h39, 8'hff);
        read_check("channel_a_reference", 8'h35, 8'ha5);
        read_check("channel_b_reference", 8'h37, 8'h5a);
        read_check("comparator_source_enable", 8'h38, 8'h3f);
        read_check("unmapped", 8'h39, 8'h00);
        // source selection for every code and input
        u_host.write_reg(8'h35, 8'h80);
        u_host.write_reg(8'h37, 8'h80);
        for (int k = 0; k < 5; k++) begin
            for (int c = 0; c < 4; c++) begin
                foreach (results[j]) results[j] = (j == k) ? 10'h3ff : 10'h000;
                u_host.write_reg(8'h38, {2'h0, c[1:0], 1'b1, c[1:0], 1'b1});
                check_cmp((c < 3) ? (k == c) : (k == 4), (c < 3) ? (k == c) : (k == 3));
            end
        end
        // compare boundaries on result bits 9..2
        refs = '{8'h80, 8'h80, 8'h80, 8'h00, 8'hff, 8'hff, 8'h7f};
        vals = '{10'h200, 10'h1ff, 10'h203, 10'h000, 10'h3fc, 10'h3fb, 10'h1ff};
        exps = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        u_host.write_reg(8'h38, 8'h09);
        foreach (refs[i]) begin
            u_host.write_reg(8'h35, refs[i]);
            u_host.write_reg(8'h37, refs[i]);
            results[0] = vals[i];
            check_cmp(exps[i], exps[i]);
        end
        // counters: rising start mode, wrong edge ignored
        u_host.write_reg(8'h35, 8'h80);
        u_host.write_reg(8'h37, 8'h80);
        results[0] = 10'h3ff;
        check_cmp(1'b1, 1'b1);
        u_host.write_reg(8'h34, 8'h85);
        u_host.write_reg(8'h36, 8'h85);
        results[0] = 10'h000;
        check_cmp(1'b0, 1'b0);
        pulse(2);
        read_check("chan_a_counter", 8'h34, 8'h85);
        read_check("chan_b_counter", 8'h36, 8'h85);
        results[0] = 10'h3ff;
        check_cmp(1'b1, 1'b1);
        pulse(3);
        read_check("chan_a_counter", 8'h34, 8'h83);
        read_check("chan_b_counter", 8'h36, 8'h83);
        // falling start mode, load disarms, saturation
        u_host.write_reg(8'h34, 8'h05);
        u_host.write_reg(8'h36, 8'h05);
        pulse(1);
        read_check("chan_a_counter", 8'h34, 8'h05);
        read_check("chan_b_counter", 8'h36, 8'h05);
        results[0] = 10'h000;
        check_cmp(1'b0, 1'b0);
        pulse(130);
        read_check("chan_a_counter", 8'h34, 8'h7f);
        read_check("chan_b_counter", 8'h36, 8'h7f);
        end_sim();
    end
endmodule
